// ---- rtl/opf_ctrl.sv ----
// option pin and supply-loss controller with Avalon-MM register slave
// Functional notes
// - all option pins are active low, inputs and outputs alike
// - test input lets software redefine pins; release restores normal use
// - captured auto-ready makes the device ready without a command
// - auto-ready level captured at power-on and every reset
// - sync pin both sends and receives low pulses
// - media writes refused while write blocking is captured
// - write-block input captured only at power-on and reset
// - activity output low while the device is active
// - fault output low while a fault exists
// - each user pin is an input or a low-active indicator
// - under warning: standby, new management commands rejected
// - warning released after assertion triggers an internal reset
`timescale 1ns/1ps
`default_nettype none
module opf_ctrl
   import opf_pkg::*;
#(
   parameter int SYNC_CW = 24,
   parameter int SYNC_WIDTH_DEF = SYNC_WIDTH_CYC,
   parameter int SYNC_PERIOD_DEF = SYNC_PERIOD_CYC,
   parameter int SYNC_MIN_DEF = SYNC_MIN_CYC
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   input wire logic test_n_i,
   input wire logic auto_ready_n_i,
   input wire logic write_block_n_i,
   input wire logic supply_loss_n_i,
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe_o,
   input wire logic [1:0] user_i,
   output logic [1:0] user_o,
   output logic [1:0] user_oe_o,
   output logic activity_n_o,
   output logic fault_n_o,
   input wire logic dev_active_i,
   input wire logic dev_fault_i,
   input wire logic media_wr_req_i,
   output logic media_wr_grant_o,
   output logic media_wr_refuse_o,
   input wire logic management_command_valid_i,
   output logic management_command_accept_o,
   output logic management_command_reject_o,
   output logic media_ready_o,
   output logic standby_o,
   output logic int_reset_o
);
   localparam logic [SYNC_CW-1:0] SW_RST = SYNC_CW'(SYNC_WIDTH_DEF);
   localparam logic [SYNC_CW-1:0] SP_RST = SYNC_CW'(SYNC_PERIOD_DEF);
   localparam logic [SYNC_CW-1:0] SM_RST = SYNC_CW'(SYNC_MIN_DEF);

   typedef struct packed {
      logic wreq;
      logic [DATA_W-1:0] rdata;
      logic [CTRL_W-1:0] ctrl;
      logic [TEST_W-1:0] test;
      logic [IRQ_N-1:0] stat;
      logic [IRQ_N-1:0] mask;
      logic [SYNC_CW-1:0] swidth;
      logic [SYNC_CW-1:0] speriod;
      logic [SYNC_CW-1:0] smin;
      logic [2:0] cap_cnt;
      opf_rdy_e rdy;
      logic auto_cap;
      logic wblk_cap;
      logic pf_seen;
      logic test_prev;
      logic irq;
      logic act_n;
      logic fault_n;
      logic sync_oe;
      logic [1:0] user_oe;
      logic grant;
      logic refuse;
      logic accept;
      logic reject;
      logic int_rst;
      logic standby;
   } opf_ct_s;
   opf_ct_s s;
   opf_ct_s next_s;

   localparam opf_ct_s ST_RST = '{
      wreq: 1'b1, rdata: '0, ctrl: CTRL_RST, test: TEST_RST,
      stat: IRQ_RST, mask: IRQ_RST, swidth: SW_RST, speriod: SP_RST,
      smin: SM_RST, cap_cnt: CAP_DLY, rdy: RDY_CAPTURE, auto_cap: 1'b0,
      wblk_cap: 1'b0, pf_seen: 1'b0, test_prev: 1'b0, irq: 1'b0,
      act_n: 1'b1, fault_n: 1'b1, sync_oe: 1'b0, user_oe: 2'h0,
      grant: 1'b0, refuse: 1'b0, accept: 1'b0, reject: 1'b0,
      int_rst: 1'b0, standby: 1'b0};

   logic [IN_N-1:0] pins_raw;
   logic [IN_N-1:0] pins;
   logic [DATA_W-1:0] rd_mux;
   logic test_on;
   logic pf_on;
   logic acc;
   logic wr_acc;

   opf_sync_if #(.CW(SYNC_CW)) sy ();

   assign pins_raw = {user_i, sync_i, supply_loss_n_i, write_block_n_i,
      auto_ready_n_i, test_n_i};

   opf_sync2 #(.W(IN_N), .RST_VAL({IN_N{1'b1}})) u_sync2
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .d_i(pins_raw),
      .q_o(pins)
   );

   opf_sync_eng #(.CW(SYNC_CW)) u_eng
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .sy(sy.eng)
   );

   // pins are low-active: a low level means asserted
   assign test_on = !pins[IN_TEST];
   assign pf_on = !pins[IN_PFAIL];
   assign acc = (avs_read_i || avs_write_i) && !s.wreq;
   assign wr_acc = avs_write_i && !s.wreq;

   assign sy.width = s.swidth;
   assign sy.period = s.speriod;
   assign sy.min_width = s.smin;
   // normal sync pulses are suspended while the tester owns the pins
   assign sy.tx_en = s.ctrl[CTRL_SYNC_TX] && !test_on;
   assign sy.force_low = test_on && s.test[TEST_SYNC];
   assign sy.pin_lvl = pins[IN_SYNC];

   function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0] be);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb
   begin
      rd_mux = '0;
      unique case (avs_address_i)
         OFF_CTRL: rd_mux = DATA_W'(s.ctrl);
         OFF_STATUS:
         begin
            rd_mux[ST_READY] = (s.rdy == RDY_READY);
            rd_mux[ST_AUTO] = s.auto_cap;
            rd_mux[ST_WBLK] = s.wblk_cap;
            rd_mux[ST_STANDBY] = s.standby;
            rd_mux[ST_TEST] = test_on;
            rd_mux[ST_USER +: 2] = ~pins[IN_USER +: 2];
            rd_mux[ST_SYNC] = !pins[IN_SYNC];
         end
         OFF_IRQ_STAT: rd_mux = DATA_W'(s.stat);
         OFF_IRQ_MASK: rd_mux = DATA_W'(s.mask);
         OFF_SYNC_WIDTH: rd_mux = DATA_W'(s.swidth);
         OFF_SYNC_PERIOD: rd_mux = DATA_W'(s.speriod);
         OFF_SYNC_MIN: rd_mux = DATA_W'(s.smin);
         OFF_TEST: rd_mux = DATA_W'(s.test);
         default: rd_mux = '0;
      endcase
   end

   always_comb
   begin
      logic [IRQ_N-1:0] ev;
      logic [IRQ_N-1:0] w1c;
      logic sw_start;
      logic soft_rst;
      ev = '0;
      w1c = '0;
      sw_start = 1'b0;
      soft_rst = 1'b0;
      next_s = s;

      // one wait state, answer on the second cycle of a request
      next_s.wreq = !((avs_read_i || avs_write_i) && s.wreq);
      if (avs_read_i && s.wreq)
      begin
         next_s.rdata = rd_mux;
      end
      if (wr_acc)
      begin
         unique case (avs_address_i)
            OFF_CTRL:
            begin
               next_s.ctrl = CTRL_W'(be_merge(DATA_W'(s.ctrl),
                  avs_writedata_i, avs_byteenable_i));
               sw_start = avs_byteenable_i[0] &&
                  avs_writedata_i[CTRL_START];
            end
            OFF_IRQ_STAT:
            begin
               w1c = IRQ_N'(be_merge('0, avs_writedata_i,
                  avs_byteenable_i));
            end
            OFF_IRQ_MASK:
            begin
               next_s.mask = IRQ_N'(be_merge(DATA_W'(s.mask),
                  avs_writedata_i, avs_byteenable_i));
            end
            OFF_SYNC_WIDTH:
            begin
               next_s.swidth = SYNC_CW'(be_merge(DATA_W'(s.swidth),
                  avs_writedata_i, avs_byteenable_i));
            end
            OFF_SYNC_PERIOD:
            begin
               next_s.speriod = SYNC_CW'(be_merge(DATA_W'(s.speriod),
                  avs_writedata_i, avs_byteenable_i));
            end
            OFF_SYNC_MIN:
            begin
               next_s.smin = SYNC_CW'(be_merge(DATA_W'(s.smin),
                  avs_writedata_i, avs_byteenable_i));
            end
            OFF_TEST:
            begin
               next_s.test = TEST_W'(be_merge(DATA_W'(s.test),
                  avs_writedata_i, avs_byteenable_i));
            end
            default:
            begin
            end
         endcase
      end
      // start is a command, not a state bit
      next_s.ctrl[CTRL_START] = 1'b0;

      // supply-loss warning and recovery
      next_s.standby = pf_on;
      next_s.int_rst = 1'b0;
      if (pf_on)
      begin
         next_s.pf_seen = 1'b1;
         ev[IRQ_PF_ASSERT] = !s.pf_seen;
      end
      else if (s.pf_seen)
      begin
         next_s.pf_seen = 1'b0;
         next_s.int_rst = 1'b1;
         soft_rst = 1'b1;
         ev[IRQ_PF_RELEASE] = 1'b1;
      end

      // strap capture after hard or internal reset
      unique case (s.rdy)
         RDY_CAPTURE:
         begin
            if (s.cap_cnt != '0)
            begin
               next_s.cap_cnt = s.cap_cnt - 3'h1;
            end
            else
            begin
               next_s.auto_cap = !pins[IN_AUTO];
               next_s.wblk_cap = !pins[IN_WBLK];
               next_s.rdy = pins[IN_AUTO] ? RDY_IDLE : RDY_READY;
            end
         end
         RDY_IDLE:
         begin
            if (sw_start)
            begin
               next_s.rdy = RDY_READY;
            end
         end
         RDY_READY:
         begin
         end
         default: next_s.rdy = RDY_CAPTURE;
      endcase
      if (soft_rst)
      begin
         next_s.rdy = RDY_CAPTURE;
         next_s.cap_cnt = CAP_DLY;
      end

      // media write gate uses the captured strap only
      next_s.grant = media_wr_req_i && !s.wblk_cap;
      next_s.refuse = media_wr_req_i && s.wblk_cap;
      ev[IRQ_WR_REFUSED] = next_s.refuse;

      // management commands arriving under warning are refused
      next_s.accept = management_command_valid_i && !pf_on;
      next_s.reject = management_command_valid_i && pf_on;
      ev[IRQ_CMD_REJECTED] = next_s.reject;

      ev[IRQ_SYNC_RX] = sy.rx_pulse;
      next_s.test_prev = test_on;
      ev[IRQ_TEST_CHANGE] = test_on != s.test_prev;

      // a new event wins over a clear in the same cycle
      next_s.stat = (s.stat & ~w1c) | ev;
      next_s.irq = |(next_s.stat & next_s.mask);

      // indicator outputs, redefined while the tester owns the pins
      if (test_on)
      begin
         next_s.act_n = !s.test[TEST_ACT];
         next_s.fault_n = !s.test[TEST_FAULT];
         next_s.user_oe = s.test[TEST_USER +: 2];
      end
      else
      begin
         next_s.act_n = !(dev_active_i || s.ctrl[CTRL_ACTIVE]);
         next_s.fault_n = !(dev_fault_i || s.ctrl[CTRL_FAULT]);
         // output only when set as indicator and switched on
         next_s.user_oe = s.ctrl[CTRL_USER_DIR +: 2] &
            s.ctrl[CTRL_USER_ON +: 2];
      end
      next_s.sync_oe = sy.drive;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s <= ST_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign avs_readdata_o = s.rdata;
   assign avs_waitrequest_o = s.wreq;
   assign irq_o = s.irq;
   // open-drain pins only ever pull low
   assign sync_o = 1'b0;
   assign sync_oe_o = s.sync_oe;
   assign user_o = 2'h0;
   assign user_oe_o = s.user_oe;
   assign activity_n_o = s.act_n;
   assign fault_n_o = s.fault_n;
   assign media_wr_grant_o = s.grant;
   assign media_wr_refuse_o = s.refuse;
   assign management_command_accept_o = s.accept;
   assign management_command_reject_o = s.reject;
   assign media_ready_o = s.rdy[1]; // only ready has bit 1
   assign standby_o = s.standby;
   assign int_reset_o = s.int_rst;
endmodule
`default_nettype wire

// ---- rtl/opf_pkg.sv ----
// shared constants and types of the option pin and supply-loss controller
package opf_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_SYNC_WIDTH = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_SYNC_PERIOD = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_SYNC_MIN = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_TEST = 5'h1c;
   // control register fields
   localparam int CTRL_W = 8;
   localparam int CTRL_START = 0;
   localparam int CTRL_ACTIVE = 1;
   localparam int CTRL_FAULT = 2;
   localparam int CTRL_SYNC_TX = 3;
   localparam int CTRL_USER_DIR = 4;
   localparam int CTRL_USER_ON = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   // test-mode drive register fields
   localparam int TEST_W = 5;
   localparam int TEST_ACT = 0;
   localparam int TEST_FAULT = 1;
   localparam int TEST_SYNC = 2;
   localparam int TEST_USER = 3;
   localparam logic [TEST_W-1:0] TEST_RST = 5'h00;
   // status register fields
   localparam int ST_READY = 0;
   localparam int ST_AUTO = 1;
   localparam int ST_WBLK = 2;
   localparam int ST_STANDBY = 3;
   localparam int ST_TEST = 4;
   localparam int ST_USER = 5;
   localparam int ST_SYNC = 7;
   // interrupt status bits
   localparam int IRQ_N = 6;
   localparam int IRQ_PF_ASSERT = 0;
   localparam int IRQ_PF_RELEASE = 1;
   localparam int IRQ_SYNC_RX = 2;
   localparam int IRQ_WR_REFUSED = 3;
   localparam int IRQ_CMD_REJECTED = 4;
   localparam int IRQ_TEST_CHANGE = 5;
   localparam logic [IRQ_N-1:0] IRQ_RST = 6'h00;
   // synchronised pin vector layout
   localparam int IN_N = 7;
   localparam int IN_TEST = 0;
   localparam int IN_AUTO = 1;
   localparam int IN_WBLK = 2;
   localparam int IN_PFAIL = 3;
   localparam int IN_SYNC = 4;
   localparam int IN_USER = 5;
   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SYNC_WIDTH_NS = 1000;
   localparam int SYNC_PERIOD_NS = 1000000;
   localparam int SYNC_MIN_NS = 500;
   localparam int SYNC_WIDTH_CYC = SYNC_WIDTH_NS * 1000 / CLK_PERIOD_PS;
   localparam int SYNC_PERIOD_CYC = SYNC_PERIOD_NS / CLK_PERIOD_PS * 1000;
   localparam int SYNC_MIN_CYC =
      (SYNC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // edges from reset release until the strap synchronisers are filled
   localparam logic [2:0] CAP_DLY = 3'h3;
   typedef enum logic [1:0]
   {
      RDY_CAPTURE = 2'h0,
      RDY_IDLE = 2'h1,
      RDY_READY = 2'h3
   } opf_rdy_e;
endpackage

// ---- rtl/opf_sync_if.sv ----
// link between controller and sync pulse engine
`timescale 1ns/1ps
`default_nettype none
interface opf_sync_if #(parameter int CW = 24);
   logic [CW-1:0] width;
   logic [CW-1:0] period;
   logic [CW-1:0] min_width;
   logic tx_en;
   logic force_low;
   logic pin_lvl;
   logic drive;
   logic rx_pulse;
   modport ctrl (output width, period, min_width, tx_en, force_low, pin_lvl,
      input drive, rx_pulse);
   modport eng (input width, period, min_width, tx_en, force_low, pin_lvl,
      output drive, rx_pulse);
endinterface
`default_nettype wire

// ---- rtl/opf_sync2.sv ----
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module opf_sync2
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } opf_sy_s;
   opf_sy_s s;
   opf_sy_s next_s;

   always_comb
   begin
      next_s.s1 = d_i;
      next_s.s2 = s.s1;
   end

   // reset to the idle level so straps do not read asserted at release
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s <= {RST_VAL, RST_VAL};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign q_o = s.s2;
endmodule
`default_nettype wire

// ---- rtl/opf_sync_eng.sv ----
// sync pulse engine: periodic low pulse out, filtered pulse detect in
`timescale 1ns/1ps
`default_nettype none
module opf_sync_eng
#(
   parameter int CW = 24
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   opf_sync_if.eng sy
);
   typedef struct packed {
      logic [CW-1:0] per_cnt;
      logic [CW-1:0] wid_cnt;
      logic [CW-1:0] low_cnt;
      logic driving;
      logic rx_pulse;
   } opf_se_s;
   opf_se_s s;
   opf_se_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.rx_pulse = 1'b0;
      if (!sy.tx_en)
      begin
         next_s.per_cnt = '0;
         next_s.wid_cnt = '0;
      end
      else if (s.per_cnt == '0)
      begin
         next_s.per_cnt = sy.period;
         next_s.wid_cnt = sy.width;
      end
      else
      begin
         next_s.per_cnt = s.per_cnt - 1'b1;
         if (s.wid_cnt != '0)
         begin
            next_s.wid_cnt = s.wid_cnt - 1'b1;
         end
      end
      next_s.driving = (next_s.wid_cnt != '0) || sy.force_low;
      // own pulse is masked while driving, but its 3-cycle low tail on the pin counts once min_width is 3 or less
      if (s.driving)
      begin
         next_s.low_cnt = '0;
      end
      else if (!sy.pin_lvl)
      begin
         if (s.low_cnt != '1)
         begin
            next_s.low_cnt = s.low_cnt + 1'b1;
         end
      end
      else
      begin
         next_s.low_cnt = '0;
         // short glitches are dropped
         if (s.low_cnt != '0 && s.low_cnt >= sy.min_width)
         begin
            next_s.rx_pulse = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sy.drive = s.driving;
   assign sy.rx_pulse = s.rx_pulse;
endmodule
`default_nettype wire

// ---- bench/opf_ctrl_checker.sv ----
// concurrent checks on the ports of the option pin controller
`timescale 1ns/1ps
`default_nettype none
module opf_ctrl_checker
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic test_n_i,
   input wire logic auto_ready_n_i,
   input wire logic supply_loss_n_i,
   input wire logic sync_o,
   input wire logic [1:0] user_o,
   input wire logic activity_n_o,
   input wire logic fault_n_o,
   input wire logic dev_active_i,
   input wire logic dev_fault_i,
   input wire logic media_wr_req_i,
   input wire logic media_wr_grant_o,
   input wire logic media_wr_refuse_o,
   input wire logic management_command_valid_i,
   input wire logic management_command_accept_o,
   input wire logic management_command_reject_o,
   input wire logic media_ready_o,
   input wire logic standby_o,
   input wire logic int_reset_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   a_bus_one_wait: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   a_wr_answer: assert property (media_wr_req_i |=>
      (media_wr_grant_o != media_wr_refuse_o))
      else $error("media write not answered once");
   a_wr_cause: assert property (media_wr_grant_o || media_wr_refuse_o |->
      $past(media_wr_req_i))
      else $error("media write answer without request");
   a_cmd_reject: assert property (management_command_valid_i && standby_o
      ##1 standby_o |-> management_command_reject_o)
      else $error("command taken in standby");
   a_cmd_accept: assert property (management_command_valid_i && !standby_o
      ##1 !standby_o |-> management_command_accept_o)
      else $error("command not accepted");
   a_standby_entry: assert property ($fell(supply_loss_n_i) ##1
      !supply_loss_n_i[*3] |-> standby_o)
      else $error("standby missing under warning");
   a_release_reset: assert property ($rose(supply_loss_n_i) && standby_o
      |-> ##[1:5] int_reset_o)
      else $error("no internal reset on release");
   a_activity_on: assert property (test_n_i[*5] ##0 dev_active_i |=>
      !activity_n_o)
      else $error("activity indicator off");
   a_fault_on: assert property (test_n_i[*5] ##0 dev_fault_i |=>
      !fault_n_o)
      else $error("fault indicator off");
   a_pins_low_only: assert property (!sync_o && user_o == 2'h0)
      else $error("pin driven high");
   a_auto_ready: assert property ($rose(rst_n_i) && !auto_ready_n_i
      |-> ##[1:8] media_ready_o)
      else $error("auto ready not reached");
endmodule
bind opf_ctrl opf_ctrl_checker opf_ctrl_checker_i (.clk_sys_i, .rst_n_i,
   .avs_read_i, .avs_write_i, .avs_waitrequest_o, .test_n_i,
   .auto_ready_n_i, .supply_loss_n_i, .sync_o, .user_o, .activity_n_o,
   .fault_n_o, .dev_active_i, .dev_fault_i, .media_wr_req_i,
   .media_wr_grant_o, .media_wr_refuse_o, .management_command_valid_i,
   .management_command_accept_o, .management_command_reject_o,
   .media_ready_o, .standby_o, .int_reset_o);
`default_nettype wire

// ---- bench/opf_backplane.sv ----
// backplane model: supply-loss warning and pulled-up shared pins
`timescale 1ns/1ps
`default_nettype none
module opf_backplane
(
   input wire logic fail_i,
   input wire logic sync_pull_i,
   input wire logic [1:0] user_pull_i,
   input wire logic sync_oe_i,
   input wire logic [1:0] user_oe_i,
   output logic supply_loss_n_o,
   output logic sync_line_o,
   output logic [1:0] user_line_o
);
   // bench raises fail well ahead of any supply drop and holds it
   assign supply_loss_n_o = !fail_i;
   // released lines float up to the pull-up level
   assign sync_line_o = !(sync_oe_i || sync_pull_i);
   assign user_line_o = ~(user_oe_i | user_pull_i);
endmodule
`default_nettype wire

// ---- bench/opf_ctrl_tb.sv ----
// self-checking bench of the option pin and supply-loss controller
`timescale 1ns/1ps
`default_nettype none
module opf_ctrl_tb;
   import opf_pkg::*;
   localparam int W_DEF = 4;
   localparam int P_DEF = 20;
   localparam int M_DEF = 3;
   typedef struct packed
   {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] exp;
   } opf_row_s;
   logic clk_sys_i, rst_n_i, avs_read_i, avs_write_i, test_n_i;
   logic auto_ready_n_i, write_block_n_i, dev_active_i, dev_fault_i;
   logic media_wr_req_i, management_command_valid_i, fail, sync_pull;
   logic [ADDR_W-1:0] avs_address_i;
   logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, rd;
   logic [1:0] user_pull, user_o, user_oe_o, user_i, r;
   logic avs_waitrequest_o, irq_o, supply_loss_n_i, sync_i, sync_o;
   logic sync_oe_o, activity_n_o, fault_n_o, media_wr_grant_o;
   logic media_wr_refuse_o, management_command_accept_o;
   logic management_command_reject_o, media_ready_o, standby_o;
   logic int_reset_o;
   int n_errors, n_compared, n;
   opf_row_s rows [14] = '{
      '{0, OFF_CTRL, 0, 0}, '{0, OFF_STATUS, 0, 0},
      '{0, OFF_IRQ_STAT, 0, 0}, '{0, OFF_IRQ_MASK, 0, 0},
      '{0, OFF_SYNC_WIDTH, 0, W_DEF}, '{0, OFF_SYNC_PERIOD, 0, P_DEF},
      '{0, OFF_SYNC_MIN, 0, M_DEF}, '{0, OFF_TEST, 0, 0},
      '{1, OFF_IRQ_MASK, 32'h3f, 32'h3f}, '{1, OFF_TEST, 32'h1f, 32'h1f},
      '{1, OFF_TEST, 0, 0}, '{1, OFF_STATUS, 32'hff, 0},
      '{1, OFF_CTRL, 32'h1, 0}, '{0, OFF_STATUS, 0, 32'h1}};
   opf_ctrl #(.SYNC_WIDTH_DEF(W_DEF), .SYNC_PERIOD_DEF(P_DEF),
      .SYNC_MIN_DEF(M_DEF)) opf_ctrl_i (.clk_sys_i, .rst_n_i,
      .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
      .irq_o, .test_n_i, .auto_ready_n_i, .write_block_n_i,
      .supply_loss_n_i, .sync_i, .sync_o, .sync_oe_o, .user_i, .user_o,
      .user_oe_o, .activity_n_o, .fault_n_o, .dev_active_i, .dev_fault_i,
      .media_wr_req_i, .media_wr_grant_o, .media_wr_refuse_o,
      .management_command_valid_i, .management_command_accept_o,
      .management_command_reject_o, .media_ready_o, .standby_o,
      .int_reset_o);
   opf_backplane opf_backplane_i (.fail_i(fail), .sync_pull_i(sync_pull),
      .user_pull_i(user_pull), .sync_oe_i(sync_oe_o), .user_oe_i(user_oe_o),
      .supply_loss_n_o(supply_loss_n_i), .sync_line_o(sync_i),
      .user_line_o(user_i));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // waits on waitrequest only; the watchdog ends a hung slave
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic op(input logic cmd);
      @(posedge clk_sys_i);
      media_wr_req_i <= !cmd;
      management_command_valid_i <= cmd;
      @(posedge clk_sys_i);
      media_wr_req_i <= 1'b0;
      management_command_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      r = cmd ? {management_command_accept_o, management_command_reject_o}
         : {media_wr_grant_o, media_wr_refuse_o};
   endtask
   task automatic do_reset;
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      #200us;
      n_errors++;
      close_out();
   end
   initial
   begin
      {rst_n_i, avs_read_i, avs_write_i, dev_active_i, dev_fault_i} = '0;
      {media_wr_req_i, management_command_valid_i, fail, sync_pull} = '0;
      {test_n_i, auto_ready_n_i, write_block_n_i} = 3'h7;
      avs_address_i = '0;
      avs_writedata_i = '0;
      user_pull = 2'h0;
      do_reset();
      foreach (rows[i])
      begin
         if (rows[i].wr)
            bus(1'b1, rows[i].addr, rows[i].data);
         bus(1'b0, rows[i].addr, 32'h0);
         chk(rd, rows[i].exp);
      end
      $display("register rows done");
      op(1'b0);
      chk(r, 2'h2);
      write_block_n_i <= 1'b0;
      auto_ready_n_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      op(1'b0);
      chk(r, 2'h2);
      do_reset();
      chk(media_ready_o, 1'b1);
      op(1'b0);
      chk(r, 2'h1);
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      chk({irq_o, rd[30:0]}, 32'h8);
      bus(1'b1, OFF_IRQ_MASK, 32'h8);
      repeat (2) @(posedge clk_sys_i);
      chk(irq_o, 1'b1);
      bus(1'b1, OFF_IRQ_STAT, 32'h8);
      repeat (2) @(posedge clk_sys_i);
      chk(irq_o, 1'b0);
      $display("write block and auto ready done");
      dev_active_i <= 1'b1;
      dev_fault_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk({activity_n_o, fault_n_o}, 2'h0);
      dev_active_i <= 1'b0;
      dev_fault_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk({activity_n_o, fault_n_o}, 2'h3);
      bus(1'b1, OFF_TEST, 32'h1);
      test_n_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      chk(activity_n_o, 1'b0);
      test_n_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      chk(activity_n_o, 1'b1);
      $display("indicator and test mode done");
      bus(1'b1, OFF_CTRL, 32'h50);
      user_pull <= 2'h2;
      repeat (4) @(posedge clk_sys_i);
      chk(user_oe_o, 2'h1);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(rd[6], 1'b1);
      user_pull <= 2'h0;
      $display("user pins done");
      fail <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      chk(standby_o, 1'b1);
      op(1'b1);
      chk(r, 2'h1);
      fail <= 1'b0;
      n = 0;
      while (int_reset_o !== 1'b1 && n < 10)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(int_reset_o, 1'b1);
      repeat (10) @(posedge clk_sys_i);
      op(1'b1);
      chk(r, 2'h2);
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      chk(rd & 32'h13, 32'h13);
      $display("supply loss done");
      bus(1'b1, OFF_CTRL, 32'h8);
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         while (sync_oe_o === k[0] && n < 60)
         begin
            @(posedge clk_sys_i);
            n++;
         end
      end
      n = 0;
      while (sync_oe_o === 1'b1 && n < 60)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(32'(n), 32'(W_DEF));
      bus(1'b1, OFF_CTRL, 32'h0);
      repeat (30) @(posedge clk_sys_i);
      for (int k = 0; k < 2; k++)
      begin
         bus(1'b1, OFF_IRQ_STAT, 32'h3f);
         sync_pull <= 1'b1;
         repeat (k ? M_DEF + 3 : M_DEF - 1) @(posedge clk_sys_i);
         sync_pull <= 1'b0;
         repeat (6) @(posedge clk_sys_i);
         bus(1'b0, OFF_IRQ_STAT, 32'h0);
         chk(rd[2], k[0]);
      end
      $display("sync pin done");
      close_out();
   end
endmodule
`default_nettype wire
